/* File: inc/sbp_pkg.sv */
// Constants, register map and types of the servo parameter block
package sbp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_INERTIA = 8'h00;
    localparam logic [7:0] OFF_GEAR_NUM = 8'h04;
    localparam logic [7:0] OFF_GEAR_DEN = 8'h08;
    localparam logic [7:0] OFF_TRQ_LIM = 8'h0C;
    localparam logic [7:0] OFF_ERR_THR = 8'h10;
    localparam logic [7:0] OFF_ENC_SEL = 8'h14;
    localparam logic [7:0] OFF_REGEN_SEL = 8'h18;
    localparam logic [7:0] OFF_CTRL = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFF_ACT_NUM = 8'h28;
    localparam logic [7:0] OFF_ACT_DEN = 8'h2C;
    localparam logic [7:0] OFF_ACT_MODE = 8'h30;
    // Reset values
    localparam logic [31:0] RST_INERTIA = 32'h0000_00FA;
    localparam logic [31:0] RST_GEAR_NUM = 32'h0000_0001;
    localparam logic [31:0] RST_GEAR_DEN = 32'h0000_0001;
    localparam logic [31:0] RST_TRQ_LIM = 32'h0000_01F4;
    localparam logic [31:0] RST_ERR_THR = 32'h0001_86A0;
    localparam logic [1:0] RST_ENC_SEL = 2'h1;
    localparam logic [1:0] RST_REGEN_SEL = 2'h3;
    // Setting range limits
    localparam logic [31:0] MAX_INERTIA = 32'h0000_2710;
    localparam logic [31:0] MAX_GEAR = 32'h4000_0000;
    localparam logic [31:0] MAX_TRQ_LIM = 32'h0000_01F4;
    localparam logic [31:0] MAX_ERR_THR = 32'h0800_0000;
    localparam logic [1:0] MAX_ENC_SEL = 2'h2;
    localparam logic [1:0] MAX_REGEN_SEL = 2'h3;
    // Encoder resolution of the 17-bit encoder
    localparam logic [31:0] ENC_RESOLUTION = 32'h0002_0000;
    // Control register bit positions
    localparam int CTRL_AUTOTUNE = 0;
    localparam int CTRL_APPLY = 1;
    // Interrupt status bit positions
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_REGEN = 1;
    localparam int IRQ_NVSAVE = 2;
    localparam int IRQ_W = 3;
    // Nonvolatile save period
    localparam longint unsigned CLK_HZ = 64'd100_000_000;
    localparam longint unsigned NV_SAVE_MIN = 64'd30;
    localparam longint unsigned NV_SAVE_CYCLES = NV_SAVE_MIN * 64'd60 * CLK_HZ;
    // Regeneration duty window and limits, in cycles per window
    localparam logic [15:0] REGEN_WINDOW = 16'h03E8;
    localparam logic [15:0] REGEN_LIM_INT = 16'h000A;
    localparam logic [15:0] REGEN_LIM_EXT = 16'h0064;
    // Regeneration resistor selections
    typedef enum logic [1:0]
    {
        SBP_REGEN_INT = 2'b00,
        SBP_REGEN_EXT = 2'b01,
        SBP_REGEN_EXT_NOALM = 2'b10,
        SBP_REGEN_NONE = 2'b11
    } sbp_regen_t;
    // Encoder usage selections
    typedef enum logic [1:0]
    {
        SBP_ENC_ABS = 2'b00,
        SBP_ENC_INC = 2'b01,
        SBP_ENC_ABS_NOOVF = 2'b10,
        SBP_ENC_RSVD = 2'b11
    } sbp_enc_t;
    // Configuration applied at reset or on the apply command
    typedef struct packed
    {
        logic [31:0] gear_num;
        logic [31:0] gear_den;
        sbp_enc_t enc_mode;
        sbp_regen_t regen_sel;
    } sbp_cfg_t;
endpackage

/* File: hdl/sbp_top.sv */
// Servo basic parameter set with APB register file and alarm logic
// Behaviour
// RULE_01: Inertia ratio 0..10000 percent, default 250.
// RULE_02: Autotune estimates inertia, saves every 30 minutes.
// RULE_03: Gear numerator 0..2^30, denominator 1..2^30, default 1.
// RULE_04: Numerator zero substitutes encoder resolution.
// RULE_05: First torque limit 0..500 percent, default 500.
// RULE_06: Torque control: first limit both directions only.
// RULE_07: Overflow threshold 0..2^27, default 100000, alarms.
// RULE_08: Threshold zero disables overflow alarm.
// RULE_09: Threshold uses selected position unit.
// RULE_10: Encoder select: absolute, incremental, absolute no-overflow.
// RULE_11: Regen 0: internal resistor, 1 percent overload.
// RULE_12: Regen 1: external resistor, trips above 10 percent.
// RULE_13: Regen 2: external resistor, overload alarm never.
// RULE_14: Regen 3: no regen processing, no alarm.
// RULE_15: Gear, encoder, regen apply at reset or command.
// RULE_16: Host avoids inertia/limit changes while moving.
// RULE_17: Out of range writes rejected, value kept.
//
// Design decisions made here: the APB register port and the register addresses.
module sbp_top
#(
    parameter longint unsigned NV_SAVE_CYC = sbp_pkg::NV_SAVE_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_torque_mode,
    input wire logic [31:0] i_sel_limit_fwd,
    input wire logic [31:0] i_sel_limit_rev,
    input wire logic [31:0] i_pos_error,
    input wire logic i_est_valid,
    input wire logic [31:0] i_inertia_est,
    input wire logic i_regen_on,
    output logic [31:0] o_torque_limit_fwd,
    output logic [31:0] o_torque_limit_rev,
    output logic [31:0] o_inertia_ratio,
    output logic o_nv_save,
    output logic [31:0] o_nv_data,
    output sbp_pkg::sbp_cfg_t o_cfg,
    output logic o_regen_enable,
    output logic o_regen_switch,
    output logic o_overflow_alarm,
    output logic o_regen_alarm,
    output logic o_irq
);
    import sbp_pkg::*;

    // Parameter register values, visible to software
    logic [31:0] load_inertia_ratio;
    logic [31:0] gear_numerator;
    logic [31:0] gear_denominator;
    logic [31:0] first_torque_limit;
    logic [31:0] following_error_threshold;
    logic [1:0] encoder_usage_select;
    logic [1:0] regen_resistor_select;
    logic autotune_en; // Realtime autotuning enable
    logic [IRQ_W-1:0] irq_status; // Sticky events
    logic [IRQ_W-1:0] irq_mask; // One enables an event's interrupt
    sbp_cfg_t act_cfg; // Configuration in force
    logic [37:0] save_cnt; // Nonvolatile save timer
    logic [15:0] win_cnt; // Regen duty window position
    logic [15:0] on_cnt; // Regen on cycles in window
    logic [31:0] err_mag; // Magnitude of position error

    // Bus decode
    logic apb_acc, wr_en, rd_en;
    logic wr_ok; // Write value inside its range
    logic addr_ok; // Mapped address
    logic apply_cmd, save_tick, win_end, ovf_evt, regen_evt;
    logic [IRQ_W-1:0] irq_set; // Events raised this cycle
    logic [15:0] regen_lim;
    logic [31:0] next_rdata;

    // One wait state: the answer comes from a flop
    assign apb_acc = i_psel && i_penable && !o_pready;
    assign wr_en = apb_acc && i_pwrite && wr_ok && addr_ok;
    assign rd_en = apb_acc && !i_pwrite;
    assign apply_cmd = wr_en && (i_paddr == OFF_CTRL)
        && i_pwdata[CTRL_APPLY];

    // Range and address check per register
    always_comb
    begin
        wr_ok = 1'b1;
        addr_ok = 1'b1;
        case (i_paddr)
            OFF_INERTIA: wr_ok = i_pwdata <= MAX_INERTIA; // RULE_17
            OFF_GEAR_NUM: wr_ok = i_pwdata <= MAX_GEAR; // RULE_17
            OFF_GEAR_DEN: wr_ok = (i_pwdata != 32'h0000_0000)
                && (i_pwdata <= MAX_GEAR); // RULE_17
            OFF_TRQ_LIM: wr_ok = i_pwdata <= MAX_TRQ_LIM; // RULE_17
            OFF_ERR_THR: wr_ok = i_pwdata <= MAX_ERR_THR; // RULE_17
            OFF_ENC_SEL: wr_ok = (i_pwdata[31:2] == 30'h0000_0000)
                && (i_pwdata[1:0] <= MAX_ENC_SEL); // RULE_17
            OFF_REGEN_SEL: wr_ok = i_pwdata[31:2] == 30'h0000_0000;
            OFF_CTRL, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_ok = 1'b1;
            OFF_ACT_NUM, OFF_ACT_DEN, OFF_ACT_MODE: wr_ok = 1'b0; // Read only
            default:
            begin
                addr_ok = 1'b0;
                wr_ok = 1'b0;
            end
        endcase
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (i_paddr)
            OFF_INERTIA: next_rdata = load_inertia_ratio;
            OFF_GEAR_NUM: next_rdata = gear_numerator;
            OFF_GEAR_DEN: next_rdata = gear_denominator;
            OFF_TRQ_LIM: next_rdata = first_torque_limit;
            OFF_ERR_THR: next_rdata = following_error_threshold;
            OFF_ENC_SEL: next_rdata = {30'h0000_0000, encoder_usage_select};
            OFF_REGEN_SEL: next_rdata = {30'h0000_0000, regen_resistor_select};
            OFF_CTRL: next_rdata = {31'h0000_0000, autotune_en};
            OFF_IRQ_STAT: next_rdata = {29'h0000_0000, irq_status};
            OFF_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
            OFF_ACT_NUM: next_rdata = act_cfg.gear_num;
            OFF_ACT_DEN: next_rdata = act_cfg.gear_den;
            OFF_ACT_MODE: next_rdata = {28'h0000_000, act_cfg.enc_mode,
                act_cfg.regen_sel};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // APB answer: ready one cycle after the access phase begins
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end
        else
        begin
            o_pready <= apb_acc;
            // Rejected writes and unmapped accesses report an error
            o_pslverr <= apb_acc && (!addr_ok || (i_pwrite && !wr_ok));
            if (rd_en)
            begin
                o_prdata <= next_rdata;
            end
        end
    end

    // Inertia ratio: software write or autotuning estimate
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            load_inertia_ratio <= RST_INERTIA; // RULE_01
        end
        else if (autotune_en && i_est_valid)
        begin
            // Estimate is clamped to the setting range
            load_inertia_ratio <= (i_inertia_est > MAX_INERTIA) ?
                MAX_INERTIA : i_inertia_est; // RULE_02
        end
        else if (wr_en && (i_paddr == OFF_INERTIA))
        begin
            // Host keeps this still while moving; it applies at once
            load_inertia_ratio <= i_pwdata; // RULE_01 RULE_16
        end
    end

    // Staged parameters that wait for reset or apply
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            gear_numerator <= RST_GEAR_NUM; // RULE_03
            gear_denominator <= RST_GEAR_DEN; // RULE_03
            encoder_usage_select <= RST_ENC_SEL; // RULE_10
            regen_resistor_select <= RST_REGEN_SEL;
        end
        else if (wr_en)
        begin
            case (i_paddr)
                OFF_GEAR_NUM: gear_numerator <= i_pwdata; // RULE_03
                OFF_GEAR_DEN: gear_denominator <= i_pwdata; // RULE_03
                OFF_ENC_SEL: encoder_usage_select <= i_pwdata[1:0];
                OFF_REGEN_SEL: regen_resistor_select <= i_pwdata[1:0];
                default: gear_numerator <= gear_numerator;
            endcase
        end
    end

    // Always-enabled parameters and control
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            first_torque_limit <= RST_TRQ_LIM; // RULE_05
            following_error_threshold <= RST_ERR_THR; // RULE_07
            autotune_en <= 1'b0;
            irq_mask <= '0;
        end
        else if (wr_en)
        begin
            case (i_paddr)
                OFF_TRQ_LIM: first_torque_limit <= i_pwdata; // RULE_05
                OFF_ERR_THR: following_error_threshold <= i_pwdata;
                OFF_CTRL: autotune_en <= i_pwdata[CTRL_AUTOTUNE];
                OFF_IRQ_MASK: irq_mask <= i_pwdata[IRQ_W-1:0];
                default: autotune_en <= autotune_en;
            endcase
        end
    end

    // Configuration in force, loaded at reset and on apply
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            act_cfg.gear_num <= RST_GEAR_NUM; // RULE_15
            act_cfg.gear_den <= RST_GEAR_DEN;
            act_cfg.enc_mode <= sbp_enc_t'(RST_ENC_SEL);
            act_cfg.regen_sel <= sbp_regen_t'(RST_REGEN_SEL);
        end
        else if (apply_cmd)
        begin
            act_cfg.gear_num <= gear_numerator; // RULE_15
            act_cfg.gear_den <= gear_denominator;
            act_cfg.enc_mode <= sbp_enc_t'(encoder_usage_select); // RULE_10
            act_cfg.regen_sel <= sbp_regen_t'(regen_resistor_select);
        end
    end

    // Effective gear ratio and encoder mode driven out
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_cfg <= '0;
        end
        else
        begin
            // Zero numerator means one revolution per denominator count
            o_cfg.gear_num <= (act_cfg.gear_num == 32'h0000_0000) ?
                ENC_RESOLUTION : act_cfg.gear_num; // RULE_04
            o_cfg.gear_den <= act_cfg.gear_den;
            o_cfg.enc_mode <= act_cfg.enc_mode; // RULE_10
            o_cfg.regen_sel <= act_cfg.regen_sel;
        end
    end

    // Torque limits; torque control bypasses the selection
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_torque_limit_fwd <= RST_TRQ_LIM;
            o_torque_limit_rev <= RST_TRQ_LIM;
            o_inertia_ratio <= RST_INERTIA;
        end
        else
        begin
            if (i_torque_mode)
            begin
                o_torque_limit_fwd <= first_torque_limit; // RULE_06
                o_torque_limit_rev <= first_torque_limit; // RULE_06
            end
            else
            begin
                o_torque_limit_fwd <= i_sel_limit_fwd;
                o_torque_limit_rev <= i_sel_limit_rev;
            end
            o_inertia_ratio <= load_inertia_ratio;
        end
    end

    // Periodic save of the estimate while autotuning runs
    assign save_tick = autotune_en
        && (save_cnt == 38'(NV_SAVE_CYC - 64'd1));
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            save_cnt <= '0;
            o_nv_save <= 1'b0;
            o_nv_data <= 32'h0000_0000;
        end
        else
        begin
            // Timer restarts whenever autotuning is off
            save_cnt <= (!autotune_en || save_tick) ? '0 : save_cnt + 38'd1;
            o_nv_save <= save_tick; // RULE_02
            if (save_tick)
            begin
                o_nv_data <= load_inertia_ratio;
            end
        end
    end

    // Error counter overflow; error is given in the selected unit
    assign err_mag = i_pos_error[31] ? (32'h0000_0000 - i_pos_error)
        : i_pos_error; // RULE_09
    assign ovf_evt = (following_error_threshold != 32'h0000_0000)
        && (err_mag > following_error_threshold); // RULE_07 RULE_08

    // Regeneration duty measured over a fixed window
    assign win_end = win_cnt == (REGEN_WINDOW - 16'd1);
    always_comb
    begin
        regen_lim = REGEN_LIM_INT;
        case (act_cfg.regen_sel)
            SBP_REGEN_INT: regen_lim = REGEN_LIM_INT; // RULE_11
            SBP_REGEN_EXT: regen_lim = REGEN_LIM_EXT; // RULE_12
            SBP_REGEN_EXT_NOALM: regen_lim = REGEN_LIM_EXT;
            SBP_REGEN_NONE: regen_lim = REGEN_LIM_EXT;
            default: regen_lim = REGEN_LIM_INT;
        endcase
    end
    // Only selections 0 and 1 alarm; the window's last cycle counts too
    assign regen_evt = win_end
        && ((on_cnt + 16'(o_regen_switch)) > regen_lim)
        && ((act_cfg.regen_sel == SBP_REGEN_INT)
        || (act_cfg.regen_sel == SBP_REGEN_EXT)); // RULE_13 RULE_14

    // Duty counters and regeneration switch drive
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            win_cnt <= 16'h0000;
            on_cnt <= 16'h0000;
            o_regen_enable <= 1'b0;
            o_regen_switch <= 1'b0;
        end
        else
        begin
            win_cnt <= win_end ? 16'h0000 : win_cnt + 16'd1;
            on_cnt <= win_end ? 16'h0000 : on_cnt + 16'(o_regen_switch);
            // Selection 3 leaves energy to the capacitor
            o_regen_enable <= act_cfg.regen_sel != SBP_REGEN_NONE; // RULE_14
            o_regen_switch <= i_regen_on
                && (act_cfg.regen_sel != SBP_REGEN_NONE); // RULE_14
        end
    end

    // Sticky event flags; a new event wins over a same-cycle clear
    assign irq_set = {save_tick, regen_evt, ovf_evt}; // RULE_07
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            irq_status <= '0;
        end
        else
        begin
            for (int b = 0; b < IRQ_W; b++)
            begin
                if (irq_set[b])
                begin
                    irq_status[b] <= 1'b1;
                end
                else if (wr_en && (i_paddr == OFF_IRQ_STAT) && i_pwdata[b])
                begin
                    irq_status[b] <= 1'b0;
                end
            end
        end
    end

    // Alarm and interrupt outputs follow the sticky flags
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_overflow_alarm <= 1'b0;
            o_regen_alarm <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_overflow_alarm <= irq_status[IRQ_OVERFLOW];
            o_regen_alarm <= irq_status[IRQ_REGEN];
            o_irq <= |(irq_status & irq_mask);
        end
    end
endmodule

/* File: testbench/sbp_top_asserts.sv */
// Port checker of the servo parameter block
module sbp_top_asserts
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic i_torque_mode,
    input wire logic [31:0] i_sel_limit_fwd,
    input wire logic [31:0] i_pos_error,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_torque_limit_fwd,
    input wire logic [31:0] o_torque_limit_rev,
    input wire logic [31:0] o_inertia_ratio,
    input wire logic o_nv_save,
    input wire sbp_pkg::sbp_cfg_t o_cfg,
    input wire logic o_regen_enable,
    input wire logic o_overflow_alarm,
    input wire logic o_regen_alarm
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbp_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    // One wait state, then a single-cycle ready
    ack_wait_a: assert property (
        i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
        else $error("ready timing wrong");
    // Addresses past the map are refused
    unmapped_err_a: assert property (
        i_psel && i_penable && !o_pready && i_paddr > OFF_ACT_MODE
        |=> o_pslverr) else $error("unmapped access accepted");
    // Estimates cannot push the ratio out of range
    inertia_range_a: assert property (
        o_inertia_ratio <= MAX_INERTIA) else $error("ratio out of range");
    // Applied gear numerator and denominator are never zero
    gear_nonzero_a: assert property (
        $past(i_nrst) |-> o_cfg.gear_num != 0 && o_cfg.gear_den != 0)
        else $error("applied gear is zero");
    // Outside torque mode the selected limit passes
    limit_pass_a: assert property (
        $past(i_nrst) && !$past(i_torque_mode)
        |-> o_torque_limit_fwd == $past(i_sel_limit_fwd))
        else $error("selected limit lost");
    // In torque mode both directions carry the same limit
    limit_same_a: assert property (
        $past(i_nrst) && $past(i_torque_mode)
        |-> o_torque_limit_fwd == o_torque_limit_rev)
        else $error("directions differ");
    // Three settled cycles cover the apply pipeline
    regen_off_a: assert property (
        (o_cfg.regen_sel == SBP_REGEN_NONE) [*3] |-> !o_regen_enable)
        else $error("regen runs under select 3");
    regen_on_a: assert property (
        (o_cfg.regen_sel != SBP_REGEN_NONE) [*3] |-> o_regen_enable)
        else $error("regen stopped");
    // Overload alarm only under selects 0 and 1
    regen_quiet_a: assert property (
        $rose(o_regen_alarm) |-> $past(o_cfg.regen_sel, 2) inside
        {SBP_REGEN_INT, SBP_REGEN_EXT}) else $error("alarm under 2 or 3");
    // Overflow needs an earlier nonzero error
    overflow_cause_a: assert property (
        $rose(o_overflow_alarm) |-> $past(i_pos_error, 2) != 32'h0)
        else $error("overflow without error");
    // Save strobe is a lone pulse
    nv_pulse_a: assert property (
        o_nv_save |=> !o_nv_save [*8]) else $error("save strobe too long");
    cover property (o_regen_alarm);
    cover property (o_overflow_alarm);
    cover property (o_nv_save);
    cover property (o_pslverr);
endmodule

/* File: testbench/sbp_motor_model.sv */
// Behavioural model of the motor, encoder and brake load
module sbp_motor_model
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [31:0] i_lag,
    input wire logic [9:0] i_duty,
    input wire logic i_tune,
    input wire logic [31:0] i_est,
    output logic [31:0] o_pos_error,
    output logic o_regen_on,
    output logic o_est_valid,
    output logic [31:0] o_inertia_est
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] ph; // Phase in the braking period
    // Period equals the duty window: i_duty on-cycles each
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ph <= 10'h0;
        else
            ph <= (ph == 10'h3E7) ? 10'h0 : ph + 10'h1;
    end
    assign o_regen_on = ph < i_duty;
    // Error is already in position units; estimate when the phase is a multiple of 16
    always_ff @(posedge i_clk)
    begin
        o_pos_error <= i_lag;
        o_est_valid <= i_tune && ph[3:0] == 4'h0;
        // Invalid slots carry the inverted estimate
        o_inertia_est <= (i_tune && ph[3:0] == 4'h0) ? i_est : ~i_est;
    end
endmodule

/* File: testbench/sbp_top_tb.sv */
// Self-checking bench of the servo parameter block
module sbp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sbp_pkg::*;
    localparam longint unsigned NV = 64'hC8; // Short save period
    logic i_clk, i_nrst, i_psel, i_penable, i_pwrite, i_torque_mode;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, i_sel_limit_fwd, i_sel_limit_rev;
    logic [31:0] o_prdata, o_torque_limit_fwd, o_torque_limit_rev;
    logic [31:0] o_inertia_ratio, o_nv_data, i_pos_error, i_inertia_est;
    logic o_pready, o_pslverr, o_nv_save, o_regen_enable, o_regen_switch;
    logic o_overflow_alarm, o_regen_alarm, o_irq, i_regen_on, i_est_valid;
    sbp_cfg_t o_cfg;
    logic [31:0] lag, est; // Motor model controls
    logic [9:0] duty;
    logic tune;
    int bad_count, checks, n;
    // Reset map: address and value
    logic [7:0] rst_a [10] = '{8'h0, 8'h4, 8'h8, 8'hC, 8'h10, 8'h14,
        8'h18, 8'h28, 8'h2C, 8'h30};
    logic [31:0] rst_v [10] = '{32'hFA, 32'h1, 32'h1, 32'h1F4, 32'h186A0,
        32'h1, 32'h3, 32'h1, 32'h1, 32'h7};
    // Range edges: address, data, refusal, readback
    logic [7:0] w_a [14] = '{8'h0, 8'h0, 8'h4, 8'h4, 8'h8, 8'h8, 8'hC,
        8'hC, 8'h10, 8'h14, 8'h14, 8'h18, 8'h28, 8'h40};
    logic [31:0] w_d [14] = '{32'h2711, 32'h2710, 32'h40000001, 32'h0,
        32'h0, 32'h40000000, 32'h1F5, 32'h64, 32'h8000001, 32'h3, 32'h2,
        32'h1, 32'h5, 32'h0};
    logic [13:0] w_e = 14'h3355;
    logic [31:0] w_b [14] = '{32'hFA, 32'h2710, 32'h1, 32'h0, 32'h1,
        32'h40000000, 32'h1F4, 32'h64, 32'h186A0, 32'h1, 32'h2, 32'h1,
        32'h1, 32'h0};
    // Regen cases: select, on-cycles per window, alarm expected
    logic [31:0] rg_s [6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h2, 32'h3};
    logic [9:0] rg_d [6] = '{10'hA, 10'hB, 10'h64, 10'h65, 10'h3E8, 10'h3E8};
    logic [5:0] rg_x = 6'hA;
    sbp_top #(.NV_SAVE_CYC(NV)) uut (.*);
    sbp_motor_model u_motor (.i_clk(i_clk), .i_nrst(i_nrst), .i_lag(lag),
        .i_duty(duty), .i_tune(tune), .i_est(est),
        .o_pos_error(i_pos_error), .o_regen_on(i_regen_on),
        .o_est_valid(i_est_valid), .o_inertia_est(i_inertia_est));
    // 100 MHz clock
    initial
    begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic chkb(input string nm, input logic x, input logic g);
        chk(nm, {31'h0, x}, {31'h0, g});
    endtask
    // One APB transfer, held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int k;
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        k = 0;
        do @(posedge i_clk); while (o_pready !== 1'h1 && ++k < 20);
        r = o_prdata;
        e = o_pslverr;
        bad_count += (k >= 20); // Lost ready fails
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic x);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
        chkb("pslverr", x, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        chk($sformatf("reg %h", a), x, r);
    endtask
    // Edges until the next save strobe
    task automatic wait_save(output int c);
        c = 0;
        do @(posedge i_clk); while (o_nv_save !== 1'h1 && ++c < 500);
    endtask
    // Main sequence
    initial
    begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_torque_mode, tune} = '0;
        {i_paddr, i_pwdata, lag, est, duty} = '0;
        i_sel_limit_fwd = 32'h12C;
        i_sel_limit_rev = 32'hC8;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'h1;
        @(posedge i_clk);
        foreach (rst_a[k]) rd(rst_a[k], rst_v[k]);
        foreach (w_a[k])
        begin
            wr(w_a[k], w_d[k], w_e[k]);
            rd(w_a[k], w_b[k]);
        end
        chk("cfg num", 32'h1, o_cfg.gear_num);
        wr(OFF_CTRL, 32'h2, 1'h0);
        repeat (2) @(posedge i_clk);
        chk("cfg num", ENC_RESOLUTION, o_cfg.gear_num);
        chk("cfg enc", 32'h2, {30'h0, o_cfg.enc_mode});
        rd(OFF_ACT_NUM, 32'h0);
        i_torque_mode <= 1'h1;
        repeat (2) @(posedge i_clk);
        chk("limit fwd", 32'h64, o_torque_limit_fwd);
        chk("limit rev", 32'h64, o_torque_limit_rev);
        i_torque_mode <= 1'h0;
        wr(OFF_IRQ_MASK, 32'h2, 1'h0);
        foreach (rg_s[k])
        begin
            duty <= 10'h0;
            repeat (1100) @(posedge i_clk);
            wr(OFF_REGEN_SEL, rg_s[k], 1'h0);
            wr(OFF_CTRL, 32'h2, 1'h0);
            wr(OFF_IRQ_STAT, 32'h3, 1'h0);
            duty <= rg_d[k];
            repeat (2100) @(posedge i_clk);
            chkb("regen alarm", rg_x[k], o_regen_alarm);
            chkb("irq", rg_x[k], o_irq);
            chkb("regen en", rg_s[k] != 32'h3, o_regen_enable);
        end
        wr(OFF_IRQ_MASK, 32'h0, 1'h0);
        wr(OFF_ERR_THR, 32'h0, 1'h0);
        lag <= 32'hFFFF_FF00;
        repeat (4) @(posedge i_clk);
        rd(OFF_IRQ_STAT, 32'h0);
        lag <= 32'hFFFF_FF9C;
        wr(OFF_ERR_THR, 32'h64, 1'h0);
        repeat (4) @(posedge i_clk);
        rd(OFF_IRQ_STAT, 32'h0);
        lag <= 32'hFFFF_FF9B;
        repeat (4) @(posedge i_clk);
        rd(OFF_IRQ_STAT, 32'h1);
        chkb("irq masked", 1'h0, o_irq);
        wr(OFF_IRQ_MASK, 32'h1, 1'h0);
        chkb("irq", 1'h1, o_irq);
        lag <= 32'h0;
        repeat (4) @(posedge i_clk);
        wr(OFF_IRQ_STAT, 32'h1, 1'h0);
        rd(OFF_IRQ_STAT, 32'h0);
        wr(OFF_INERTIA, 32'h5, 1'h0);
        rd(OFF_INERTIA, 32'h5);
        est <= 32'h12C;
        tune <= 1'h1;
        wr(OFF_CTRL, 32'h1, 1'h0);
        wait_save(n);
        wait_save(n);
        chk("save gap", 32'hC7, 32'(n));
        chk("nv data", 32'h12C, o_nv_data);
        rd(OFF_INERTIA, 32'h12C);
        rd(OFF_IRQ_STAT, 32'h4);
        end_sim();
    end
    // Watchdog, well past the 20000-cycle run
    initial
    begin
        repeat (60000) @(posedge i_clk);
        bad_count++;
        end_sim();
    end
endmodule
bind sbp_top sbp_top_asserts u_chk (.*);
